// ### logic/gpio5_pkg.sv
// package for the five-bit port block: register map, field positions, reset values, carriers
// assumes a 32-bit AHB-Lite slave with one aligned word per register
// What this block does
// - five bidirectional pins 0..4, each with a port, direction and output latch bit.
// - direction bit 0 drives the pin from its latch bit, 1 makes it an input read back through the port register.
// - an active peripheral forces a pin to output or input regardless of the direction bit.
// - a peripheral override is never stored in the direction register, so read-modify-write keeps software values.
// - port register bits 7, 6, 5 hold the pull-up enables of ports D, E and J; setting one enables them.
// - direction register bits 7, 6, 5 select open-drain drive for SPI, capture/compare two and one.
// - output latch bit 6 makes the first serial port's output open-drain.
// - output latch bit 7 makes pin 1 open-drain while the second serial module is active.
// - output latch bit 5 is not implemented and reads as zero.
// - on the 64-pin variant the port J pull-up enable is unimplemented and reads as zero.
// - the second serial module's transmit or sync data output on pin 1 or 2 takes priority over latch data.
// - with direction 1, pin 1 feeds the sync clock input and pin 2 the async receive input of the serial module.
package gpio5_pkg;
    localparam int PINS = 5;
    localparam logic [7:0] OFS_PORT = 8'h00;
    localparam logic [7:0] OFS_LATCH = 8'h04;
    localparam logic [7:0] OFS_DIR = 8'h08;
    localparam int B_PU_D = 7;
    localparam int B_PU_E = 6;
    localparam int B_PU_J = 5;
    localparam int B_OD_SPI = 7;
    localparam int B_OD_CC2 = 6;
    localparam int B_OD_CC1 = 5;
    localparam int B_OD_SER2 = 7;
    localparam int B_OD_SER1 = 6;
    localparam logic [7:0] LATCH_MASK = 8'hDF;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    // serial module pin requests
    typedef struct packed {
        logic active;
        logic tx_en;
        logic tx;
        logic dt_en;
        logic dt;
    } serial2_req_s;
    // open-drain and pull-up selects towards other blocks
    typedef struct packed {
        logic port_d_pullup_en;
        logic port_e_pullup_en;
        logic port_j_pullup_en;
        logic spi_open_drain_sel;
        logic capcmp2_open_drain_sel;
        logic capcmp1_open_drain_sel;
        logic serial1_open_drain_sel;
    } side_ctl_s;
endpackage

// ### logic/gpio5_port.sv
// five-bit bidirectional port with AHB-Lite register access
// assumes pins arrive asynchronously; serial module signals share clk
`timescale 1ns/100ps
module gpio5_port #(
    parameter bit PIN64 = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    input wire logic [4:0] periph_force_out,
    input wire logic [4:0] periph_force_in,
    input wire logic [4:0] periph_out,
    input wire gpio5_pkg::serial2_req_s ser2,
    output logic serial2_sync_clock,
    output logic serial2_async_rx,
    output logic serial2_sync_data,
    output gpio5_pkg::side_ctl_s side_ctl
);
    logic [7:0] pullup_reg;
    logic [7:0] latch_reg;
    logic [7:0] dir_reg;
    logic [7:0] pullup_next;
    logic [7:0] latch_next;
    logic [7:0] dir_next;
    logic [4:0] sync1_reg;
    logic [4:0] pin_sync_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] rd_data;
    logic [4:0] out_val;
    logic [4:0] dir_eff;
    logic [4:0] drv;
    logic [4:0] od;
    logic take;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && hready && (htrans == gpio5_pkg::HTRANS_NONSEQ || htrans == gpio5_pkg::HTRANS_SEQ);

    // two-stage pin synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
        end else begin
            sync1_reg <= pin_in;
            pin_sync_reg <= sync1_reg;
        end
    end

    // address phase capture for writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= take && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // next register values: only a completed write data phase loads the addressed register
    always_comb begin
        pullup_next = pullup_reg;
        latch_next = latch_reg;
        dir_next = dir_reg;
        if (wr_pend_reg && hready) begin
            if (wr_addr_reg == gpio5_pkg::OFS_PORT) begin
                latch_next[4:0] = hwdata[4:0];
                pullup_next = {hwdata[7:6], hwdata[5] & ~PIN64, 5'h00};
            end else if (wr_addr_reg == gpio5_pkg::OFS_LATCH) begin
                latch_next = hwdata[7:0] & gpio5_pkg::LATCH_MASK;
            end else if (wr_addr_reg == gpio5_pkg::OFS_DIR) begin
                dir_next = hwdata[7:0];
            end
        end
    end

    // pull-up enables for the three neighbouring ports
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pullup_reg <= gpio5_pkg::PORT_RST;
        end else begin
            pullup_reg <= pullup_next;
        end
    end

    // output latch and serial open-drain selects
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_reg <= gpio5_pkg::LATCH_RST;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // direction bits; peripheral overrides never land here, so read-modify-write stays safe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_reg <= gpio5_pkg::DIR_RST;
        end else begin
            dir_reg <= dir_next;
        end
    end

    // read mux, registered at the address phase; a write finishing on the same edge is forwarded
    // so that a back-to-back read after write returns the new value
    always_comb begin
        rd_data = 8'h00;
        if (haddr[7:0] == gpio5_pkg::OFS_PORT) begin
            rd_data = {pullup_next[7:5], pin_sync_reg};
        end else if (haddr[7:0] == gpio5_pkg::OFS_LATCH) begin
            rd_data = latch_next & gpio5_pkg::LATCH_MASK;
        end else if (haddr[7:0] == gpio5_pkg::OFS_DIR) begin
            rd_data = dir_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= {24'h00_0000, rd_data};
        end
    end

    // effective direction and output value per pin
    always_comb begin
        dir_eff = (dir_reg[4:0] | periph_force_in) & ~periph_force_out;
        out_val = (latch_reg[4:0] & ~periph_force_out) | (periph_out & periph_force_out);
        if (ser2.tx_en) begin
            dir_eff[1] = 1'b0;
            out_val[1] = ser2.tx;
        end
        if (ser2.dt_en) begin
            dir_eff[2] = 1'b0;
            out_val[2] = ser2.dt;
        end
        od = 5'h00;
        od[1] = ser2.active && latch_reg[gpio5_pkg::B_OD_SER2];
        drv = ~dir_eff & ~(od & out_val);
    end

    // pin drivers registered for clean outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= 5'h00;
            pin_oe <= 5'h00;
        end else begin
            pin_out <= out_val & ~od;
            pin_oe <= drv;
        end
    end

    // serial inputs and side controls
    always_comb begin
        serial2_sync_clock = pin_sync_reg[1] & dir_reg[1];
        serial2_async_rx = pin_sync_reg[2] & dir_reg[2];
        serial2_sync_data = pin_sync_reg[2];
        side_ctl.port_d_pullup_en = pullup_reg[gpio5_pkg::B_PU_D];
        side_ctl.port_e_pullup_en = pullup_reg[gpio5_pkg::B_PU_E];
        side_ctl.port_j_pullup_en = pullup_reg[gpio5_pkg::B_PU_J] & ~PIN64;
        side_ctl.spi_open_drain_sel = dir_reg[gpio5_pkg::B_OD_SPI];
        side_ctl.capcmp2_open_drain_sel = dir_reg[gpio5_pkg::B_OD_CC2];
        side_ctl.capcmp1_open_drain_sel = dir_reg[gpio5_pkg::B_OD_CC1];
        side_ctl.serial1_open_drain_sel = latch_reg[gpio5_pkg::B_OD_SER1];
    end

    // checks
    property p_lat5_zero;
        @(posedge clk) disable iff (!arst_n) latch_reg[5] == 1'b0;
    endproperty
    a_lat5_zero: assert property (p_lat5_zero) else $error("latch bit 5 set");

    property p_dir_out;
        @(posedge clk) disable iff (!arst_n)
        (!dir_reg[0] && !periph_force_in[0] && !periph_force_out[0]) |=> pin_oe[0] && pin_out[0] == $past(latch_reg[0]);
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("pin 0 not driven from latch");

    property p_dir_in;
        @(posedge clk) disable iff (!arst_n) (dir_reg[3] && !periph_force_out[3]) |=> !pin_oe[3];
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("input pin driven");

    property p_force_out;
        @(posedge clk) disable iff (!arst_n) periph_force_out[4] |=> pin_oe[4];
    endproperty
    a_force_out: assert property (p_force_out) else $error("override ignored");

    property p_tx_prio;
        @(posedge clk) disable iff (!arst_n)
        (ser2.tx_en && !od[1]) |=> pin_oe[1] && pin_out[1] == $past(ser2.tx);
    endproperty
    a_tx_prio: assert property (p_tx_prio) else $error("serial tx lost priority");

    property p_dir_keep;
        @(posedge clk) disable iff (!arst_n) !wr_pend_reg |=> $stable(dir_reg);
    endproperty
    a_dir_keep: assert property (p_dir_keep) else $error("direction changed without write");

    property p_od_pin1;
        @(posedge clk) disable iff (!arst_n)
        (ser2.active && latch_reg[7] && ser2.tx_en && ser2.tx) |=> !pin_oe[1];
    endproperty
    a_od_pin1: assert property (p_od_pin1) else $error("pin 1 drove high in open-drain");

    property p_pu_j;
        @(posedge clk) disable iff (!arst_n) PIN64 |-> !side_ctl.port_j_pullup_en;
    endproperty
    a_pu_j: assert property (p_pu_j) else $error("port J pull-up on small variant");

    // shared sequences for the multi-step checks
    // a write address phase to one offset whose data phase completes on the next edge
    sequence s_wr_data(logic [7:0] ofs);
        (take && hwrite && haddr[7:0] == ofs) ##1 hready;
    endsequence

    // pin 1 held as input for three edges out of reset, long enough to cross the synchroniser
    sequence s_pin1_in;
        (arst_n && dir_reg[1]) ##1 dir_reg[1] ##1 dir_reg[1];
    endsequence

    // pin 2 held as input for three edges out of reset
    sequence s_pin2_in;
        (arst_n && dir_reg[2]) ##1 dir_reg[2] ##1 dir_reg[2];
    endsequence

    // three edges out of reset, after which the synchroniser holds real pin history
    sequence s_settled;
        arst_n ##2 1'b1;
    endsequence

    property p_dir_write;
        @(posedge clk) disable iff (!arst_n)
        s_wr_data(gpio5_pkg::OFS_DIR) |=> dir_reg == $past(hwdata[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_latch_write;
        @(posedge clk) disable iff (!arst_n)
        s_wr_data(gpio5_pkg::OFS_LATCH) |=> latch_reg == ($past(hwdata[7:0]) & gpio5_pkg::LATCH_MASK);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write wrong");

    property p_port_latch;
        @(posedge clk) disable iff (!arst_n)
        s_wr_data(gpio5_pkg::OFS_PORT) |=> latch_reg[4:0] == $past(hwdata[4:0]);
    endproperty
    a_port_latch: assert property (p_port_latch) else $error("port write missed the latch");

    property p_port_pullup;
        @(posedge clk) disable iff (!arst_n)
        s_wr_data(gpio5_pkg::OFS_PORT) |=> pullup_reg[7:6] == $past(hwdata[7:6]);
    endproperty
    a_port_pullup: assert property (p_port_pullup) else $error("pull-up enables not stored");

    property p_read_port;
        @(posedge clk) disable iff (!arst_n)
        (take && !hwrite && haddr[7:0] == gpio5_pkg::OFS_PORT) |=>
        hrdata[4:0] == $past(pin_sync_reg) && hrdata[31:8] == 24'h00_0000;
    endproperty
    a_read_port: assert property (p_read_port) else $error("port read lost pin levels");

    property p_sync_clk;
        @(posedge clk) disable iff (!arst_n)
        s_pin1_in |-> serial2_sync_clock == $past(pin_in[1], 2);
    endproperty
    a_sync_clk: assert property (p_sync_clk) else $error("sync clock input not from pin 1");

    property p_async_rx;
        @(posedge clk) disable iff (!arst_n)
        s_pin2_in |-> serial2_async_rx == $past(pin_in[2], 2);
    endproperty
    a_async_rx: assert property (p_async_rx) else $error("receive input not from pin 2");

    property p_sync_data;
        @(posedge clk) disable iff (!arst_n)
        s_settled |-> serial2_sync_data == $past(pin_in[2], 2);
    endproperty
    a_sync_data: assert property (p_sync_data) else $error("sync data input not from pin 2");

    property p_od_low;
        @(posedge clk) disable iff (!arst_n)
        (ser2.active && latch_reg[gpio5_pkg::B_OD_SER2] && ser2.tx_en && !ser2.tx) |=> pin_oe[1] && !pin_out[1];
    endproperty
    a_od_low: assert property (p_od_low) else $error("pin 1 not pulled low in open-drain");

    property p_dt_prio;
        @(posedge clk) disable iff (!arst_n)
        ser2.dt_en |=> pin_oe[2] && pin_out[2] == $past(ser2.dt);
    endproperty
    a_dt_prio: assert property (p_dt_prio) else $error("serial data lost priority");

    property p_force_in;
        @(posedge clk) disable iff (!arst_n)
        (periph_force_in[0] && !periph_force_out[0]) |=> !pin_oe[0];
    endproperty
    a_force_in: assert property (p_force_in) else $error("input override ignored");
endmodule

// ### sim/pin_partner.sv
// pin-side model: resolves each pin from port drive and an external driver
// assumes external drive changes only right after a rising clk edge
`timescale 1ns/100ps
module pin_partner (
    input wire logic clk,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_val,
    output logic [4:0] pin_lvl
);
    logic [4:0] float_reg = 5'h0A;
    // an undriven line wanders every cycle, so stale values never pass
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    // port drive wins, then the external driver, else the floating pattern
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & float_reg);
endmodule

// ### sim/tb_gpio5_port.sv
// self-checking bench for the five-bit port
// assumes zero-wait AHB-Lite slave, offsets from the package
`timescale 1ns/100ps
module tb_gpio5_port;
    logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [4:0] pin_in, pin_out, pin_oe, ext_en = 5'h1F, ext_val = 5'h0A;
    logic [4:0] f_out = 5'h00, f_in = 5'h00, p_out = 5'h00;
    logic s_clk, s_rx, s_dt;
    gpio5_pkg::serial2_req_s ser2 = '0;
    gpio5_pkg::side_ctl_s side_ctl;
    int miscompares = 0, n_checks = 0;
    gpio5_port u_gpio5_port (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .periph_force_out(f_out), .periph_force_in(f_in), .periph_out(p_out), .ser2(ser2),
        .serial2_sync_clock(s_clk), .serial2_async_rx(s_rx), .serial2_sync_data(s_dt), .side_ctl(side_ctl));
    pin_partner u_pin_partner (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_lvl(pin_in));
    // free-running clock
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one wait for hready, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= gpio5_pkg::HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, {24'h0, exp});
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_reset;
        rchk(gpio5_pkg::OFS_DIR, 8'hFF);
        rchk(gpio5_pkg::OFS_LATCH, 8'h00);
        rchk(gpio5_pkg::OFS_PORT, 8'h0A);
        // direction resets to all ones, so the three peripheral open-drain selects start set
        chk({25'h0, side_ctl}, 32'h0000_000E);
        rchk(8'h20, 8'h00);
    endtask
    task automatic t_latch_dir;
        bus(gpio5_pkg::OFS_LATCH, 1'b1, 32'hFF);
        rchk(gpio5_pkg::OFS_LATCH, 8'hDF);
        ext_en <= 5'h00;
        bus(gpio5_pkg::OFS_DIR, 1'b1, 32'h00);
        settle(2);
        chk({22'h0, pin_oe, pin_out}, 32'h3FF);
        chk({31'h0, side_ctl.serial1_open_drain_sel}, 32'h1);
        settle(2);
        rchk(gpio5_pkg::OFS_PORT, 8'h1F);
    endtask
    task automatic t_port;
        bus(gpio5_pkg::OFS_PORT, 1'b1, 32'hE5);
        rchk(gpio5_pkg::OFS_LATCH, 8'hC5);
        settle(3);
        rchk(gpio5_pkg::OFS_PORT, 8'hE5);
        chk({29'h0, side_ctl[6:4]}, 32'h7);
        bus(gpio5_pkg::OFS_DIR, 1'b1, 32'hE0);
        settle(1);
        chk({29'h0, side_ctl[3:1]}, 32'h7);
    endtask
    task automatic t_periph;
        bus(gpio5_pkg::OFS_DIR, 1'b1, 32'hE8);
        f_out <= 5'h08;
        p_out <= 5'h08;
        f_in <= 5'h01;
        settle(2);
        chk({27'h0, pin_oe}, 32'h1E);
        chk({31'h0, pin_out[3]}, 32'h1);
        rchk(gpio5_pkg::OFS_DIR, 8'hE8);
        f_out <= 5'h00;
        f_in <= 5'h00;
    endtask
    task automatic t_serial;
        bus(gpio5_pkg::OFS_DIR, 1'b1, 32'hE6);
        ext_en <= 5'h06;
        ext_val <= 5'h02;
        settle(3);
        chk({29'h0, s_clk, s_rx, s_dt}, 32'h4);
        @(posedge clk);
        ext_val <= 5'h04;
        settle(3);
        chk({29'h0, s_clk, s_rx, s_dt}, 32'h3);
        @(posedge clk);
        ser2 <= 5'b11011;
        settle(2);
        chk({28'h0, pin_oe[2:1], pin_out[2:1]}, 32'hE);
        @(posedge clk);
        ser2 <= 5'b11111;
        settle(2);
        chk({31'h0, pin_oe[1]}, 32'h0);
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_latch_dir();
        t_port();
        t_periph();
        t_serial();
        report_and_stop();
    end
endmodule
